/* mlu_pkg.sv */
`default_nettype none
package mlu_pkg;

    // Bus geometry
    localparam int              ADDR_W      = 12;
    localparam int              DATA_W      = 32;

    // Lock slot array
    localparam int              NUM_SLOTS   = 16;
    localparam int              SLOT_IDX_W  = $clog2(NUM_SLOTS);
    localparam logic [ADDR_W-1:0] SLOT_BASE = 12'h400;
    localparam logic [ADDR_W-1:0] SLOT_STRIDE = 12'h004;
    localparam logic [ADDR_W-1:0] SLOT_LAST =
        ADDR_W'(SLOT_BASE + (NUM_SLOTS - 1) * SLOT_STRIDE);

    // Side-effect free snapshot of all slots
    localparam logic [ADDR_W-1:0] STATUS_OFF = 12'h000;

    // Values after reset
    localparam logic [NUM_SLOTS-1:0] SLOTS_RST = 16'h0000;

    // Slot decode, shared by the datapath and its checks
    function automatic logic mlu_slot_hit(input logic [ADDR_W-1:0] a);
        return (a >= SLOT_BASE) && (a <= SLOT_LAST) && (a[1:0] == 2'h0);
    endfunction : mlu_slot_hit

    function automatic logic [SLOT_IDX_W-1:0] mlu_slot_idx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - SLOT_BASE;
        return off[SLOT_IDX_W+1:2];
    endfunction : mlu_slot_idx

endpackage : mlu_pkg
`default_nettype wire

/* mlu_arb.sv */
`timescale 1ns/1ns
`default_nettype none
module mlu_arb
    import mlu_pkg::*;
#(
    parameter int NP = 2,
    parameter int PW = (NP > 1) ? $clog2(NP) : 1
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic [NP-1:0] req,
    output var  logic [PW-1:0] first_q
);

    logic [PW-1:0] first_d;

    // Rotate only on a collision so no port is starved of first place
    always_comb begin
        first_d = first_q;
        if ($countones(req) > 1) begin
            if (int'(first_q) == NP - 1) begin
                first_d = '0;
            end else begin
                first_d = PW'(int'(first_q) + 1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            first_q <= '0;
        end else begin
            first_q <= first_d;
        end
    end

endmodule : mlu_arb
`default_nettype wire

/* mlu_lock_unit.sv */
// Strobed register access was decided locally.
`timescale 1ns/1ns
`default_nettype none
module mlu_lock_unit
    import mlu_pkg::*;
#(
    parameter int NP = 2
) (
    input  wire logic                 CLK,
    input  wire logic                 SYS_RST,
    input  wire logic [NP*ADDR_W-1:0] ADDR,
    input  wire logic [NP*DATA_W-1:0] WDATA,
    input  wire logic [NP-1:0]        WR,
    input  wire logic [NP-1:0]        RD,
    output var  logic [NP*DATA_W-1:0] RDATA,
    output var  logic [NUM_SLOTS-1:0] LOCK_HELD
);

    localparam int PW = (NP > 1) ? $clog2(NP) : 1;

    logic [NUM_SLOTS-1:0] held_q;
    logic [NUM_SLOTS-1:0] held_d;
    logic [NP*DATA_W-1:0] rdata_d;
    logic [PW-1:0]        first_q;

    // Round-robin order of service among ports that collide
    mlu_arb #(
        .NP (NP),
        .PW (PW)
    ) u_arb (
        .clk     (CLK),
        .rst     (SYS_RST),
        .req     (RD | WR),
        .first_q (first_q)
    );

    // Serve ports one after another inside the cycle; each sees the last's result.
    // Keeps every access single-cycle so no master is ever stalled.
    always_comb begin
        logic [NUM_SLOTS-1:0]  st;
        logic [ADDR_W-1:0]     a;
        logic [DATA_W-1:0]     wd;
        logic [SLOT_IDX_W-1:0] ix;
        int                    p;
        st      = held_q;
        rdata_d = '0;
        a       = '0;
        wd      = '0;
        ix      = '0;
        p       = 0;
        // Later ports see earlier ports' effects, which is how colliding accesses serialise
        for (int k = 0; k < NP; k++) begin
            p  = (int'(first_q) + k) % NP;
            a  = ADDR[p*ADDR_W +: ADDR_W];
            wd = WDATA[p*DATA_W +: DATA_W];
            ix = mlu_slot_idx(a);
            if (RD[p] && mlu_slot_hit(a)) begin
                // Old state goes out, slot ends held either way
                rdata_d[p*DATA_W +: DATA_W] = DATA_W'(st[ix]);
                st[ix] = 1'b1;
            end else if (RD[p] && (a == STATUS_OFF)) begin
                rdata_d[p*DATA_W +: DATA_W] = DATA_W'(st);
            end else if (WR[p] && mlu_slot_hit(a) && (wd == '0)) begin
                st[ix] = 1'b0;
            end
            // Nonzero writes and unmapped addresses fall through untouched
        end
        held_d = st;
    end

    // Slot state; only bus accesses move it
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            held_q <= SLOTS_RST;
        end else begin
            held_q <= held_d;
        end
    end

    // Read data stand for the cycle after the strobe only
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            RDATA <= '0;
        end else begin
            RDATA <= rdata_d;
        end
    end

    // Mirror of slot state for observers, from a flop
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            LOCK_HELD <= SLOTS_RST;
        end else begin
            LOCK_HELD <= held_d;
        end
    end

    // Checks of slot behaviour, written for the two-port build
    if (NP == 2) begin : g_chk
        logic [ADDR_W-1:0]     a0;
        logic [ADDR_W-1:0]     a1;
        logic                  hit0;
        logic                  hit1;
        logic [SLOT_IDX_W-1:0] ix0;
        logic [SLOT_IDX_W-1:0] ix1;
        logic                  solo0;
        logic                  solo1;
        logic                  own0;

        assign a0    = ADDR[ADDR_W-1:0];
        assign a1    = ADDR[2*ADDR_W-1:ADDR_W];
        assign hit0  = mlu_slot_hit(a0);
        assign hit1  = mlu_slot_hit(a1);
        assign ix0   = mlu_slot_idx(a0);
        assign ix1   = mlu_slot_idx(a1);
        assign solo0 = !RD[1] && !WR[1];
        assign solo1 = !RD[0] && !WR[0];
        assign own0  = held_q[ix0];

        // Port 0 slot behaviour; port 1 kept idle or served behind it
        a_free_read_claims: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            RD[0] && hit0 && !held_q[ix0] && !WR[1] && (first_q == '0 || !RD[1])
            |=> RDATA[0] == 1'b0 && held_q[$past(ix0)] && LOCK_HELD[$past(ix0)]
        ) else $error("free slot read did not return 0 and claim");

        a_held_read_one: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            RD[0] && hit0 && held_q[ix0] && !WR[1]
            |=> RDATA[0] == 1'b1 && held_q[$past(ix0)]
        ) else $error("held slot read did not return 1");

        a_read_single_bit: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            RD[0] && hit0 |=> RDATA[DATA_W-1:1] == '0
        ) else $error("slot read carried more than one bit");

        a_zero_write_frees: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            WR[0] && hit0 && WDATA[DATA_W-1:0] == '0 && !RD[1] && held_q[ix0]
            |=> !held_q[$past(ix0)]
        ) else $error("write of 0 did not free held slot");

        a_free_write_noop: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            WR[0] && hit0 && WDATA[DATA_W-1:0] == '0 && solo0 && !held_q[ix0]
            |=> held_q == $past(held_q)
        ) else $error("write of 0 to free slot changed state");

        a_nonzero_ignored: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            WR[0] && WDATA[DATA_W-1:0] != '0 && solo0
            |=> held_q == $past(held_q)
        ) else $error("nonzero write changed slot state");

        a_reset_all_free: assert property (
            @(posedge CLK)
            SYS_RST |=> held_q == '0 && LOCK_HELD == '0
        ) else $error("slots not free after reset");

        a_no_self_release: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            (|(held_q & ~held_d)) |-> (|WR)
        ) else $error("slot freed without a write");

        a_one_winner: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            RD[0] && RD[1] && hit0 && hit1 && ix0 == ix1 && !held_q[ix0]
            |=> (RDATA[0] ^ RDATA[DATA_W]) && held_q[$past(ix0)]
        ) else $error("colliding reads did not give one winner");

        a_last_slot_map: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            RD[0] && a0 == SLOT_LAST && !held_q[NUM_SLOTS-1] && !WR[1]
            && (first_q == '0 || !RD[1])
            |=> held_q[NUM_SLOTS-1] && LOCK_HELD[NUM_SLOTS-1] && RDATA[0] == 1'b0
        ) else $error("last slot address did not claim last slot");

        // Port 1 mirrors; the far port is kept quiet or ordered behind
        a_p1_free_claims: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            RD[1] && hit1 && !held_q[ix1] && !WR[0] && (first_q == PW'(1) || !RD[0])
            |=> RDATA[DATA_W] == 1'b0 && held_q[$past(ix1)] && LOCK_HELD[$past(ix1)]
        ) else $error("port 1 free slot read did not return 0 and claim");

        a_p1_held_one: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            RD[1] && hit1 && held_q[ix1] && !WR[0]
            |=> RDATA[DATA_W] == 1'b1 && held_q[$past(ix1)]
        ) else $error("port 1 held slot read did not return 1");

        a_p1_single_bit: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            RD[1] && hit1 |=> RDATA[2*DATA_W-1:DATA_W+1] == '0
        ) else $error("port 1 slot read carried more than one bit");

        a_p1_zero_frees: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            WR[1] && hit1 && WDATA[2*DATA_W-1:DATA_W] == '0 && !RD[0] && held_q[ix1]
            |=> !held_q[$past(ix1)]
        ) else $error("port 1 write of 0 did not free held slot");

        a_p1_free_noop: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            WR[1] && hit1 && WDATA[2*DATA_W-1:DATA_W] == '0 && solo1 && !held_q[ix1]
            |=> held_q == $past(held_q)
        ) else $error("port 1 write of 0 to free slot changed state");

        a_p1_nonzero_ignored: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            WR[1] && WDATA[2*DATA_W-1:DATA_W] != '0 && solo1
            |=> held_q == $past(held_q)
        ) else $error("port 1 nonzero write changed slot state");

        // Read data stand one cycle only, so an idle port must show zero
        a_idle_rdata_p0: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            !RD[0] |=> RDATA[DATA_W-1:0] == '0
        ) else $error("port 0 read data stood without a read");

        a_idle_rdata_p1: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            !RD[1] |=> RDATA[2*DATA_W-1:DATA_W] == '0
        ) else $error("port 1 read data stood without a read");

        // Status snapshot must never claim a slot
        a_status_no_side: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            RD[0] && a0 == STATUS_OFF && solo0
            |=> RDATA[DATA_W-1:0] == DATA_W'($past(held_q)) && held_q == $past(held_q)
        ) else $error("status read changed slots or misreported them");

        // Holes in the map read as zero and are inert
        a_unmapped_quiet: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            RD[0] && !hit0 && a0 != STATUS_OFF && solo0
            |=> RDATA[DATA_W-1:0] == '0 && held_q == $past(held_q)
        ) else $error("read outside the slot map touched a slot");

        // Pointer moves only on a collision, so a lone master never loses its turn
        a_arb_rotates: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            (RD[0] || WR[0]) && (RD[1] || WR[1]) |=> first_q != $past(first_q)
        ) else $error("arbiter did not rotate after a collision");

        a_arb_holds: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            !((RD[0] || WR[0]) && (RD[1] || WR[1])) |=> first_q == $past(first_q)
        ) else $error("arbiter moved without a collision");

        // Reset clears the answer path as well
        a_reset_rdata_zero: assert property (
            @(posedge CLK)
            SYS_RST |=> RDATA == '0
        ) else $error("read data not cleared by reset");

        // Same-cycle write of 0 and read of one slot resolve in service order
        a_serial_write_read: assert property (
            @(posedge CLK) disable iff (SYS_RST)
            WR[0] && hit0 && WDATA[DATA_W-1:0] == '0 && RD[1] && hit1 && ix1 == ix0
            |=> (($past(first_q) == '0) ? (RDATA[DATA_W] == 1'b0 && held_q[$past(ix0)])
                : (RDATA[DATA_W] == $past(own0) && !held_q[$past(ix0)]))
        ) else $error("write and read of one slot not served in order");

        // Main scenarios worth seeing at least once

        c_claim_release: cover property (
            @(posedge CLK) disable iff (SYS_RST)
            RD[0] && hit0 && !held_q[ix0] ##[1:20] WR[0] && hit0 && WDATA[DATA_W-1:0] == '0
        );

        c_collision: cover property (
            @(posedge CLK) disable iff (SYS_RST)
            RD[0] && RD[1] && hit0 && hit1 && ix0 == ix1 && !held_q[ix0]
        );

        c_busy_read: cover property (
            @(posedge CLK) disable iff (SYS_RST)
            RD[1] && hit1 && held_q[ix1]
        );

        c_status_read: cover property (
            @(posedge CLK) disable iff (SYS_RST)
            RD[0] && a0 == STATUS_OFF
        );

        c_write_read_race: cover property (
            @(posedge CLK) disable iff (SYS_RST)
            WR[0] && hit0 && RD[1] && hit1 && ix1 == ix0
        );
    end

endmodule : mlu_lock_unit
`default_nettype wire

/* mlu_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module mlu_core_model
    import mlu_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [DATA_W-1:0] rdata,
    output var  logic [ADDR_W-1:0] addr,
    output var  logic [DATA_W-1:0] wdata,
    output var  logic              wr,
    output var  logic              rd
);
    // Idle bus at time zero
    initial begin
        addr  = '0;
        wdata = '0;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // One word access; released lines flip so stale values never look valid
    task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
        #1 q = rdata;
    endtask : access

    // Claim, use the shared resource briefly, then free; a loser never touches it
    task automatic claim_use_free(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
        access(1'b0, a, '0, q);
        if (q === '0) begin
            repeat (2) @(posedge clk);
            access(1'b1, a, '0, q);
            q = '0;
        end
    endtask : claim_use_free
endmodule : mlu_core_model
`default_nettype wire

/* multicore_lock_unit_test.sv */
`timescale 1ns/1ns
`default_nettype none
module multicore_lock_unit_test;
    import mlu_pkg::*;
    logic                 clk;
    logic                 sys_rst;
    logic [ADDR_W-1:0]    a0, a1;
    logic [DATA_W-1:0]    d0, d1, g0, g1;
    logic                 w0, w1, r0, r1;
    logic [2*DATA_W-1:0]  rdata;
    logic [NUM_SLOTS-1:0] held;
    int                   failures;
    int                   samples_checked;
    int                   model [NUM_SLOTS];

    mlu_lock_unit #(.NP(2)) i_mlu_lock_unit (.CLK(clk), .SYS_RST(sys_rst), .ADDR({a1, a0}),
        .WDATA({d1, d0}), .WR({w1, w0}), .RD({r1, r0}), .RDATA(rdata), .LOCK_HELD(held));
    mlu_core_model i_core0 (.clk(clk), .rdata(rdata[DATA_W-1:0]), .addr(a0), .wdata(d0),
        .wr(w0), .rd(r0));
    mlu_core_model i_core1 (.clk(clk), .rdata(rdata[2*DATA_W-1:DATA_W]), .addr(a1),
        .wdata(d1), .wr(w1), .rd(r1));

    function automatic logic [NUM_SLOTS-1:0] model_vec();
        logic [NUM_SLOTS-1:0] v;
        for (int n = 0; n < NUM_SLOTS; n++) begin
            v[n] = (model[n] != 0);
        end
        return v;
    endfunction : model_vec

    task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_held();
        samples_checked++;
        if (held !== model_vec()) begin
            failures++;
            $display("Error at %0t: held %h, expected %h", $time, held, model_vec());
        end
    endtask : check_held

    // One access by core c, predicted from the slot model first
    task automatic op(input int c, input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] q;
        logic [DATA_W-1:0] exp;
        int                idx;
        idx = (a >= 12'h400 && a <= 12'h43c && a[1:0] == 2'h0) ? int'(a - 12'h400) / 4 : -1;
        exp = (a == 12'h000) ? DATA_W'(model_vec()) : (idx >= 0) ? DATA_W'(model[idx]) : '0;
        if (c == 0) begin
            i_core0.access(w, a, d, q);
        end else begin
            i_core1.access(w, a, d, q);
        end
        if (w && idx >= 0 && d == '0) begin
            model[idx] = 0;
        end
        if (!w) begin
            check_word(q, exp);
            if (idx >= 0) model[idx] = 1;
        end
        check_held();
    endtask : op

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Watchdog, several times the expected run
    initial begin
        #(40 * 6000);
        failures++;
        give_verdict();
    end

    initial begin
        failures = 0;
        samples_checked = 0;
        sys_rst = 1'b1;
        foreach (model[n]) model[n] = 0;
        void'($urandom(83431));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        op(0, 1'b0, 12'h000, '0);
        for (int n = 0; n < NUM_SLOTS; n++) begin
            op($urandom_range(1), 1'b0, 12'h400 + 12'(4 * n), '0);
            op($urandom_range(1), 1'b0, 12'h400 + 12'(4 * n), '0);
            op($urandom_range(1), 1'b1, 12'h400 + 12'(4 * n), $urandom | 32'h1);
        end
        $display("Test claim sweep done");
        for (int n = 0; n < NUM_SLOTS; n++) begin
            op(n % 2, 1'b1, 12'h400 + 12'(4 * n), '0);
        end
        op(1, 1'b1, 12'h400, '0);
        op(0, 1'b0, 12'h440, '0);
        op(1, 1'b0, 12'h402, '0);
        op(0, 1'b1, 12'h440, '0);
        $display("Test release done");
        op(1, 1'b0, 12'h414, '0);
        repeat (60) @(posedge clk);
        check_held();
        op(1, 1'b1, 12'h414, '0);
        $display("Test no self release done");
        repeat (3) begin
            fork
                i_core0.claim_use_free(12'h424, g0);
                i_core1.claim_use_free(12'h424, g1);
            join
            check_word(g0 + g1, 32'h1);
            check_held();
        end
        fork
            i_core0.access(1'b1, 12'h424, '0, g0);
            i_core1.access(1'b0, 12'h424, '0, g1);
        join
        check_word(g1, 32'h0);
        op(0, 1'b1, 12'h424, '0);
        $display("Test collision done");
        repeat (250) begin
            op($urandom_range(1), 1'($urandom_range(1)),
               ($urandom_range(7) == 0) ? 12'h440 : 12'h400 + 12'(4 * $urandom_range(15)),
               $urandom_range(1) ? '0 : $urandom);
        end
        $display("Test random done");
        give_verdict();
    end
endmodule : multicore_lock_unit_test
`default_nettype wire
